// >>> verilog/bdm_register_file.sv
// Purpose: Banked data memory and special-function register file
// Assumes: Core presents one access per cycle; read data registered on clock edge, writes on clock edge
// Notes: Peripheral engines live outside; their registers are held here
`default_nettype none
module bdm_register_file
	import bdm_pkg::*;
(
	input wire logic CLOCK_IN,
	input wire logic RST_IN,
	input wire logic POWER_ON_RST_IN,
	input wire logic BROWN_OUT_RST_IN,
	input wire logic [6:0] FILE_ADDR_IN,
	input wire logic READ_IN,
	input wire logic WRITE_IN,
	input wire logic [7:0] WDATA_IN,
	input wire logic PC_LOAD_IN,
	input wire logic [7:0] PC_LOW_NEXT_IN,
	input wire logic STATUS_FLAGS_WE_IN,
	input wire logic [2:0] STATUS_FLAGS_IN,
	input wire logic TIMEOUT_SET_IN,
	input wire logic POWERDOWN_SET_IN,
	input wire logic [7:0] PORT_A_PINS_IN,
	input wire logic [7:0] PORT_B_PINS_IN,
	output logic [7:0] RDATA_OUT,
	output logic [12:0] PC_OUT,
	output logic [7:0] STATUS_OUT,
	output logic [7:0] OPTIONS_OUT,
	output logic [7:0] INTERRUPT_CONTROL_OUT,
	output logic [7:0] PORT_A_DIRECTION_OUT,
	output logic [7:0] PORT_B_DIRECTION_OUT,
	output logic [7:0] CCP_PIN_DIRECTION_OUT,
	output logic [7:0] PERIPH_IRQ_ENABLES_OUT,
	output logic [7:0] CONVERTER_CONTROL_B_OUT
);
	localparam int NREG = 17;

	logic [7:0] status_r;
	logic [7:0] pointer_r;
	logic [7:0] pc_low_r;
	logic [4:0] pc_high_r;
	logic [4:0] pc_latch_r;
	logic [7:0] interrupt_control_r;
	logic [7:0] options_r;
	logic [7:0] dir_a_r;
	logic [7:0] dir_b_r;
	logic [7:0] dir_ccp_r;
	logic [7:0] pie_r;
	logic [7:0] power_reset_flags_r;
	logic [7:0] period_r;
	logic [7:0] conv_b_r;
	logic [7:0] plain_r [NREG];
	logic [7:0] pa_s1_r;
	logic [7:0] pa_s2_r;
	logic [7:0] pb_s1_r;
	logic [7:0] pb_s2_r;
	bdm_rst_kind_t rst_kind;
	logic [7:0] file_addr;
	logic [7:0] eff_addr;
	logic [7:0] map_addr;
	logic is_indirect;
	logic bank_ok;
	logic wr;
	logic ram_we;
	logic [6:0] ram_idx;
	logic [7:0] ram_rdata;
	logic in_gpr0;
	logic in_gpr1;
	logic [7:0] rdata_c;

	// Plain peripheral register offsets, bank 0 plus two bank 1 entries
	localparam logic [7:0] PLAIN_ADDR [NREG] = '{
		ADDR_TIMER0_COUNT, ADDR_PORT_A_DATA, ADDR_PORT_B_DATA, ADDR_CCP_PIN_DATA,
		ADDR_PERIPH_IRQ_FLAGS, ADDR_TIMER1_LOW, ADDR_TIMER1_HIGH, ADDR_TIMER1_CONTROL,
		ADDR_TIMER2_COUNT, ADDR_TIMER2_CONTROL, ADDR_CAPCMP_LOW, ADDR_CAPCMP_HIGH,
		ADDR_CAPCMP_CONTROL, ADDR_CONVERTER_RESULT, ADDR_CONVERTER_CONTROL_A,
		ADDR_TIMER2_PERIOD, ADDR_CONVERTER_CONTROL_B
	};

	// Reset kind, power-on highest priority
	always_comb
	begin
		if (POWER_ON_RST_IN)
			rst_kind = BDM_RST_POWER;
		else if (BROWN_OUT_RST_IN)
			rst_kind = BDM_RST_BROWN;
		else if (RST_IN)
			rst_kind = BDM_RST_OTHER;
		else
			rst_kind = BDM_RST_NONE;
	end

	// Address formation
	assign file_addr = {status_r[STAT_BANK_LOW], FILE_ADDR_IN};
	assign is_indirect = (FILE_ADDR_IN == ADDR_INDIRECT_PORT[6:0]);
	assign eff_addr = is_indirect ? pointer_r : file_addr;
	// Bank bits 10/11 address nothing; indirect bank bit is not implemented
	assign bank_ok = is_indirect ? 1'b1 : !status_r[STAT_BANK_HIGH];
	// Mirrored registers fold onto bank 0 addresses
	always_comb
	begin
		map_addr = eff_addr;
		case (eff_addr[6:0])
			ADDR_INDIRECT_PORT[6:0], ADDR_PC_LOW_BYTE[6:0], ADDR_CORE_STATUS[6:0],
			ADDR_INDIRECT_POINTER[6:0], ADDR_PC_HIGH_LATCH[6:0], ADDR_INTERRUPT_CONTROL[6:0]:
				map_addr = {1'b0, eff_addr[6:0]};
			default:
				map_addr = eff_addr;
		endcase
	end
	// No stores while any reset is active
	assign wr = WRITE_IN && (rst_kind == BDM_RST_NONE) && bank_ok
		&& !(is_indirect && pointer_r[6:0] == ADDR_INDIRECT_PORT[6:0]);

	// General-purpose storage windows
	assign in_gpr0 = (map_addr >= GPR0_BASE) && (map_addr <= GPR0_LAST);
	assign in_gpr1 = (map_addr >= GPR1_BASE) && (map_addr <= GPR1_LAST);
	assign ram_idx = in_gpr1 ? 7'(GPR0_BYTES + int'(map_addr - GPR1_BASE)) : 7'(map_addr - GPR0_BASE);
	assign ram_we = wr && (in_gpr0 || in_gpr1);

	bdm_gpr_ram #(
		.DEPTH(GPR0_BYTES + GPR1_BYTES),
		.AW(7)
	) u_ram (
		.clk_in(CLOCK_IN),
		.we_in(ram_we),
		.idx_in(ram_idx),
		.wdata_in(WDATA_IN),
		.rdata_out(ram_rdata)
	);

	// Storage must fit the seven-bit index
	if (GPR0_BYTES + GPR1_BYTES > 128)
	begin : g_size_check
		$error("bdm_register_file storage exceeds index range");
	end

	// Pin synchronisers
	always_ff @(posedge CLOCK_IN)
	begin
		pa_s1_r <= PORT_A_PINS_IN;
		pa_s2_r <= pa_s1_r;
		pb_s1_r <= PORT_B_PINS_IN;
		pb_s2_r <= pb_s1_r;
	end

	// Core status
	always_ff @(posedge CLOCK_IN)
	begin
		if (rst_kind == BDM_RST_POWER || rst_kind == BDM_RST_BROWN)
			status_r <= RST_STATUS_POR;
		else if (rst_kind == BDM_RST_OTHER)
			status_r <= {3'b000, status_r[4:3], status_r[2:0]};
		else
		begin
			if (wr && map_addr == ADDR_CORE_STATUS)
				status_r <= {WDATA_IN[7:5], status_r[4:3], WDATA_IN[2:0]};
			// Flag pulse beats a bus write of the same bits
			if (STATUS_FLAGS_WE_IN)
				status_r[2:0] <= STATUS_FLAGS_IN;
			if (TIMEOUT_SET_IN)
				status_r[STAT_TIMEOUT] <= 1'b0;
			if (POWERDOWN_SET_IN)
				status_r[STAT_POWERDOWN] <= 1'b0;
		end
	end

	// Indirect pointer, unchanged by non-power resets
	always_ff @(posedge CLOCK_IN)
	begin
		if (rst_kind == BDM_RST_POWER || rst_kind == BDM_RST_BROWN)
			pointer_r <= RST_ZERO;
		else if (rst_kind == BDM_RST_NONE && wr && map_addr == ADDR_INDIRECT_POINTER)
			pointer_r <= WDATA_IN;
	end

	// Program counter and high latch
	always_ff @(posedge CLOCK_IN)
	begin
		if (rst_kind != BDM_RST_NONE)
		begin
			pc_low_r <= RST_ZERO;
			pc_high_r <= 5'h00;
			pc_latch_r <= 5'h00;
		end
		else
		begin
			if (wr && map_addr == ADDR_PC_HIGH_LATCH)
				pc_latch_r <= WDATA_IN[4:0];
			// Bus write of pc low beats a core load
			if (wr && map_addr == ADDR_PC_LOW_BYTE)
			begin
				pc_low_r <= WDATA_IN;
				pc_high_r <= pc_latch_r;
			end
			else if (PC_LOAD_IN)
			begin
				pc_low_r <= PC_LOW_NEXT_IN;
				pc_high_r <= pc_latch_r;
			end
		end
	end

	// Interrupt control; bit 0 unchanged on non-power resets
	always_ff @(posedge CLOCK_IN)
	begin
		if (rst_kind == BDM_RST_POWER || rst_kind == BDM_RST_BROWN)
			interrupt_control_r <= RST_ZERO;
		else if (rst_kind == BDM_RST_OTHER)
			interrupt_control_r <= {7'h00, interrupt_control_r[0]};
		else if (wr && map_addr == ADDR_INTERRUPT_CONTROL)
			interrupt_control_r <= WDATA_IN;
	end

	// Bank 1 configuration registers
	always_ff @(posedge CLOCK_IN)
	begin
		if (rst_kind != BDM_RST_NONE)
		begin
			options_r <= RST_ALL_ONES;
			dir_a_r <= RST_PORT_A_DIR;
			dir_b_r <= RST_ALL_ONES;
			dir_ccp_r <= RST_CCP_DIR;
			pie_r <= RST_ZERO;
			period_r <= RST_ALL_ONES;
			conv_b_r <= RST_ZERO;
		end
		else if (wr)
		begin
			case (map_addr)
				ADDR_CORE_OPTIONS: options_r <= WDATA_IN;
				ADDR_PORT_A_DIRECTION: dir_a_r <= WDATA_IN & MASK_PORT_A_DIR;
				ADDR_PORT_B_DIRECTION: dir_b_r <= WDATA_IN;
				ADDR_CCP_PIN_DIRECTION: dir_ccp_r <= WDATA_IN & MASK_CCP_DIR;
				ADDR_PERIPH_IRQ_ENABLES: pie_r <= WDATA_IN & MASK_PIE;
				ADDR_TIMER2_PERIOD: period_r <= WDATA_IN;
				ADDR_CONVERTER_CONTROL_B: conv_b_r <= WDATA_IN & MASK_CONV_B;
				default: ;
			endcase
		end
	end

	// Reset cause flags
	always_ff @(posedge CLOCK_IN)
	begin
		if (rst_kind == BDM_RST_POWER)
			power_reset_flags_r <= RST_POWER_RESET_FLAGS_POR;
		else if (rst_kind == BDM_RST_BROWN)
			power_reset_flags_r <= RST_POWER_RESET_FLAGS_BOR;
		else if (rst_kind == BDM_RST_NONE && wr && map_addr == ADDR_POWER_RESET_FLAGS)
			power_reset_flags_r <= WDATA_IN & MASK_POWER_RESET_FLAGS;
	end

	// Bank 0 peripheral holding registers
	genvar g;
	generate
		for (g = 0; g < NREG; g++)
		begin : g_plain
			if (PLAIN_ADDR[g] < 8'h80 && PLAIN_ADDR[g] != ADDR_TIMER2_PERIOD)
			begin : g_impl
				always_ff @(posedge CLOCK_IN)
				begin
					if (rst_kind == BDM_RST_POWER || rst_kind == BDM_RST_BROWN)
						plain_r[g] <= RST_ZERO;
					else if (rst_kind == BDM_RST_NONE && wr && map_addr == PLAIN_ADDR[g])
						plain_r[g] <= (PLAIN_ADDR[g] == ADDR_PERIPH_IRQ_FLAGS) ? (WDATA_IN & MASK_PIR) : WDATA_IN;
				end
			end
			else
			begin : g_none
				assign plain_r[g] = RST_ZERO;
			end
		end
	endgenerate

	// Read mux
	always_comb
	begin
		rdata_c = 8'h00;
		if (bank_ok)
		begin
			case (map_addr)
				ADDR_INDIRECT_PORT: rdata_c = 8'h00;
				ADDR_PC_LOW_BYTE: rdata_c = pc_low_r;
				ADDR_CORE_STATUS: rdata_c = status_r;
				ADDR_INDIRECT_POINTER: rdata_c = pointer_r;
				ADDR_PC_HIGH_LATCH: rdata_c = {3'b000, pc_latch_r};
				ADDR_INTERRUPT_CONTROL: rdata_c = interrupt_control_r;
				ADDR_PORT_A_DATA: rdata_c = (pa_s2_r & dir_a_r) | (plain_r[1] & ~dir_a_r & MASK_PORT_A_DIR);
				ADDR_PORT_B_DATA: rdata_c = (pb_s2_r & dir_b_r) | (plain_r[2] & ~dir_b_r);
				ADDR_CORE_OPTIONS: rdata_c = options_r;
				ADDR_PORT_A_DIRECTION: rdata_c = dir_a_r;
				ADDR_PORT_B_DIRECTION: rdata_c = dir_b_r;
				ADDR_CCP_PIN_DIRECTION: rdata_c = dir_ccp_r;
				ADDR_PERIPH_IRQ_ENABLES: rdata_c = pie_r;
				ADDR_POWER_RESET_FLAGS: rdata_c = power_reset_flags_r;
				ADDR_TIMER2_PERIOD: rdata_c = period_r;
				ADDR_CONVERTER_CONTROL_B: rdata_c = conv_b_r;
				default:
				begin
					if (in_gpr0 || in_gpr1)
						rdata_c = ram_rdata;
					else
					begin
						for (int i = 0; i < NREG; i++)
							if (map_addr == PLAIN_ADDR[i] && PLAIN_ADDR[i] < 8'h80)
								rdata_c = plain_r[i];
					end
				end
			endcase
		end
	end

	// Read data register
	always_ff @(posedge CLOCK_IN)
	begin
		if (rst_kind != BDM_RST_NONE)
			RDATA_OUT <= RST_ZERO;
		else if (READ_IN)
			RDATA_OUT <= rdata_c;
	end

	assign PC_OUT = {pc_high_r, pc_low_r};
	assign STATUS_OUT = status_r;
	assign OPTIONS_OUT = options_r;
	assign INTERRUPT_CONTROL_OUT = interrupt_control_r;
	assign PORT_A_DIRECTION_OUT = dir_a_r;
	assign PORT_B_DIRECTION_OUT = dir_b_r;
	assign CCP_PIN_DIRECTION_OUT = dir_ccp_r;
	assign PERIPH_IRQ_ENABLES_OUT = pie_r;
	assign CONVERTER_CONTROL_B_OUT = conv_b_r;
endmodule
`default_nettype wire

// >>> verilog/bdm_pkg.sv
// Purpose: Constants for the banked data memory and register file
// Assumes: 8-bit data, 7-bit file address plus one bank bit
// Notes: Offsets are 8-bit full data addresses
`default_nettype none
package bdm_pkg;
	localparam logic [7:0] ADDR_INDIRECT_PORT = 8'h00;
	localparam logic [7:0] ADDR_TIMER0_COUNT = 8'h01;
	localparam logic [7:0] ADDR_PC_LOW_BYTE = 8'h02;
	localparam logic [7:0] ADDR_CORE_STATUS = 8'h03;
	localparam logic [7:0] ADDR_INDIRECT_POINTER = 8'h04;
	localparam logic [7:0] ADDR_PORT_A_DATA = 8'h05;
	localparam logic [7:0] ADDR_PORT_B_DATA = 8'h06;
	localparam logic [7:0] ADDR_CCP_PIN_DATA = 8'h07;
	localparam logic [7:0] ADDR_PC_HIGH_LATCH = 8'h0A;
	localparam logic [7:0] ADDR_INTERRUPT_CONTROL = 8'h0B;
	localparam logic [7:0] ADDR_PERIPH_IRQ_FLAGS = 8'h0C;
	localparam logic [7:0] ADDR_TIMER1_LOW = 8'h0E;
	localparam logic [7:0] ADDR_TIMER1_HIGH = 8'h0F;
	localparam logic [7:0] ADDR_TIMER1_CONTROL = 8'h10;
	localparam logic [7:0] ADDR_TIMER2_COUNT = 8'h11;
	localparam logic [7:0] ADDR_TIMER2_CONTROL = 8'h12;
	localparam logic [7:0] ADDR_CAPCMP_LOW = 8'h15;
	localparam logic [7:0] ADDR_CAPCMP_HIGH = 8'h16;
	localparam logic [7:0] ADDR_CAPCMP_CONTROL = 8'h17;
	localparam logic [7:0] ADDR_CONVERTER_RESULT = 8'h1E;
	localparam logic [7:0] ADDR_CONVERTER_CONTROL_A = 8'h1F;
	localparam logic [7:0] ADDR_CORE_OPTIONS = 8'h81;
	localparam logic [7:0] ADDR_PORT_A_DIRECTION = 8'h85;
	localparam logic [7:0] ADDR_PORT_B_DIRECTION = 8'h86;
	localparam logic [7:0] ADDR_CCP_PIN_DIRECTION = 8'h87;
	localparam logic [7:0] ADDR_PERIPH_IRQ_ENABLES = 8'h8C;
	localparam logic [7:0] ADDR_POWER_RESET_FLAGS = 8'h8E;
	localparam logic [7:0] ADDR_TIMER2_PERIOD = 8'h92;
	localparam logic [7:0] ADDR_CONVERTER_CONTROL_B = 8'h9F;
	// General-purpose storage windows
	localparam logic [7:0] GPR0_BASE = 8'h20;
	localparam logic [7:0] GPR0_LAST = 8'h7F;
	localparam logic [7:0] GPR1_BASE = 8'hA0;
	localparam logic [7:0] GPR1_LAST = 8'hBF;
	localparam int GPR0_BYTES = 96;
	localparam int GPR1_BYTES = 32;
	// Status field positions
	localparam int STAT_IND_BANK = 7;
	localparam int STAT_BANK_HIGH = 6;
	localparam int STAT_BANK_LOW = 5;
	localparam int STAT_TIMEOUT = 4;
	localparam int STAT_POWERDOWN = 3;
	// Implemented bit masks
	localparam logic [7:0] MASK_PORT_A_DIR = 8'h3F;
	localparam logic [7:0] MASK_CCP_DIR = 8'h05;
	localparam logic [7:0] MASK_PC_HIGH = 8'h1F;
	localparam logic [7:0] MASK_PIE = 8'h47;
	localparam logic [7:0] MASK_PIR = 8'h47;
	localparam logic [7:0] MASK_POWER_RESET_FLAGS = 8'h03;
	localparam logic [7:0] MASK_CONV_B = 8'h07;
	// Reset values
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_ALL_ONES = 8'hFF;
	localparam logic [7:0] RST_STATUS_POR = 8'h18;
	localparam logic [7:0] RST_PORT_A_DIR = 8'h3F;
	localparam logic [7:0] RST_CCP_DIR = 8'h05;
	localparam logic [7:0] RST_POWER_RESET_FLAGS_POR = 8'h00;
	localparam logic [7:0] RST_POWER_RESET_FLAGS_BOR = 8'h02;
	typedef enum logic [1:0]
	{
		BDM_RST_NONE = 2'b00,
		BDM_RST_POWER = 2'b01,
		BDM_RST_BROWN = 2'b10,
		BDM_RST_OTHER = 2'b11
	} bdm_rst_kind_t;
endpackage
`default_nettype wire

// >>> verilog/bdm_gpr_ram.sv
// Purpose: General-purpose static storage, flip-flop array
// Assumes: Write and read share one index, read is combinational
// Notes: Contents are not cleared by reset
`default_nettype none
module bdm_gpr_ram #(
	parameter int DEPTH = 128,
	parameter int AW = 7
)(
	input wire logic clk_in,
	input wire logic we_in,
	input wire logic [AW-1:0] idx_in,
	input wire logic [7:0] wdata_in,
	output logic [7:0] rdata_out
);
	logic [7:0] mem_r [DEPTH];
	if (DEPTH < 1 || DEPTH > (1 << AW))
	begin : g_depth_check
		$error("bdm_gpr_ram depth exceeds index range");
	end
	always_ff @(posedge clk_in)
	begin
		if (we_in && (int'(idx_in) < DEPTH))
			mem_r[idx_in] <= wdata_in;
	end
	assign rdata_out = (int'(idx_in) < DEPTH) ? mem_r[idx_in] : 8'h00;
endmodule
`default_nettype wire

// >>> verification/bdm_register_file_assertions.sv
// Purpose: Port checks for the banked register file
// Assumes: Power-on reset disables all checks
// Notes: Bound to every register file instance
`default_nettype none
module bdm_register_file_checker (
	input wire logic CLOCK_IN,
	input wire logic RST_IN,
	input wire logic POWER_ON_RST_IN,
	input wire logic BROWN_OUT_RST_IN,
	input wire logic [6:0] FILE_ADDR_IN,
	input wire logic READ_IN,
	input wire logic WRITE_IN,
	input wire logic [7:0] WDATA_IN,
	input wire logic PC_LOAD_IN,
	input wire logic [7:0] PC_LOW_NEXT_IN,
	input wire logic STATUS_FLAGS_WE_IN,
	input wire logic [7:0] RDATA_OUT,
	input wire logic [12:0] PC_OUT,
	input wire logic [7:0] STATUS_OUT,
	input wire logic [7:0] PORT_A_DIRECTION_OUT,
	input wire logic [7:0] PORT_B_DIRECTION_OUT,
	input wire logic [7:0] CCP_PIN_DIRECTION_OUT,
	input wire logic [7:0] PERIPH_IRQ_ENABLES_OUT,
	input wire logic [7:0] CONVERTER_CONTROL_B_OUT
);
	timeunit 1ns;
	timeprecision 1ps;
	logic any_rst;
	assign any_rst = RST_IN || BROWN_OUT_RST_IN;
	default clocking @(posedge CLOCK_IN); endclocking
	default disable iff (POWER_ON_RST_IN);
	a_power_status: assert property ($fell(POWER_ON_RST_IN) |-> STATUS_OUT == 8'h18)
		else $error("Status wrong after power reset");
	a_brown_status: assert property (BROWN_OUT_RST_IN |=> STATUS_OUT == 8'h18)
		else $error("Status wrong after brown reset");
	a_other_status: assert property ((RST_IN && !BROWN_OUT_RST_IN) |=>
		STATUS_OUT[7:5] == 3'h0 && STATUS_OUT[4:0] == $past(STATUS_OUT[4:0]))
		else $error("Status wrong after pin reset");
	a_dir_reset: assert property (any_rst |=> PORT_B_DIRECTION_OUT == 8'hFF &&
		PORT_A_DIRECTION_OUT == 8'h3F && CCP_PIN_DIRECTION_OUT == 8'h05)
		else $error("Direction not input after reset");
	a_rdata_hold: assert property ((!READ_IN && !any_rst) |=> $stable(RDATA_OUT))
		else $error("Read data moved without read");
	a_pc_load: assert property ((PC_LOAD_IN && !any_rst) |=> PC_OUT[7:0] == $past(PC_LOW_NEXT_IN))
		else $error("Pc low not loaded");
	a_pc_quiet: assert property ((!PC_LOAD_IN && !WRITE_IN && !any_rst) |=> $stable(PC_OUT))
		else $error("Pc moved without load");
	a_bank_write: assert property ((WRITE_IN && FILE_ADDR_IN == 7'h03 && !STATUS_OUT[6] && !any_rst
		&& !STATUS_FLAGS_WE_IN) |=> (STATUS_OUT & 8'h60) == ($past(WDATA_IN) & 8'h60))
		else $error("Bank bits not written");
	a_dirb_write: assert property ((WRITE_IN && FILE_ADDR_IN == 7'h06 && STATUS_OUT[6:5] == 2'b01
		&& !any_rst) |=> PORT_B_DIRECTION_OUT == $past(WDATA_IN))
		else $error("Bank one direction write lost");
	a_pie_write: assert property ((WRITE_IN && FILE_ADDR_IN == 7'h0C && STATUS_OUT[6:5] == 2'b01
		&& !any_rst) |=> PERIPH_IRQ_ENABLES_OUT == ($past(WDATA_IN) & 8'h47))
		else $error("Enable write wrong");
	a_unused_bits: assert property (((PERIPH_IRQ_ENABLES_OUT & 8'hB8) | (CONVERTER_CONTROL_B_OUT
		& 8'hF8) | (PORT_A_DIRECTION_OUT & 8'hC0)) == 8'h00)
		else $error("Unimplemented bit set");
endmodule
bind bdm_register_file bdm_register_file_checker u_bdm_register_file_checker (.CLOCK_IN, .RST_IN,
	.POWER_ON_RST_IN, .BROWN_OUT_RST_IN, .FILE_ADDR_IN, .READ_IN, .WRITE_IN, .WDATA_IN, .PC_LOAD_IN,
	.PC_LOW_NEXT_IN, .STATUS_FLAGS_WE_IN, .RDATA_OUT, .PC_OUT, .STATUS_OUT, .PORT_A_DIRECTION_OUT,
	.PORT_B_DIRECTION_OUT, .CCP_PIN_DIRECTION_OUT, .PERIPH_IRQ_ENABLES_OUT, .CONVERTER_CONTROL_B_OUT);
`default_nettype wire

// >>> verification/bdm_core_model.sv
// Purpose: Core side access driver
// Assumes: One access per call, driven at falling edge
// Notes: Idle lines carry inverted last values
`default_nettype none
module bdm_core_model (
	input wire logic clk_in,
	input wire logic [7:0] rdata_in,
	output logic [6:0] file_addr_out,
	output logic read_out,
	output logic write_out,
	output logic [7:0] wdata_out
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		file_addr_out = 7'h7F;
		read_out = 1'b0;
		write_out = 1'b0;
		wdata_out = 8'hFF;
	end
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(negedge clk_in);
		file_addr_out = a;
		wdata_out = (a == 7'h03) ? (d & 8'h3F) : d;
		write_out = 1'b1;
		@(negedge clk_in);
		write_out = 1'b0;
		file_addr_out = ~a;
		wdata_out = ~wdata_out;
	endtask
	task automatic rd(input logic [6:0] a, output logic [7:0] d);
		@(negedge clk_in);
		file_addr_out = a;
		read_out = 1'b1;
		@(negedge clk_in);
		read_out = 1'b0;
		file_addr_out = ~a;
		d = rdata_in;
	endtask
endmodule
`default_nettype wire

// >>> verification/testbench.sv
// Purpose: Self-checking bench for the register file
// Assumes: Inputs change at the falling edge
// Notes: Pins and status flag inputs are driven by the bench
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import bdm_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic por = 1'b1;
	logic bor = 1'b0;
	logic pc_ld = 1'b0;
	logic [7:0] pc_nx = 8'h00;
	logic [7:0] pins_b = 8'hA5;
	logic [7:0] pins_a = 8'h00;
	logic flg_we = 1'b0;
	logic [2:0] flg = 3'h0;
	logic to_clr = 1'b0;
	logic pd_clr = 1'b0;
	logic [7:0] opts;
	logic [7:0] intc;
	logic [6:0] addr;
	logic rd_s;
	logic wr_s;
	logic [7:0] wd;
	logic [7:0] rdata;
	logic [12:0] pc;
	logic [7:0] status;
	logic [7:0] dir_b;
	int mismatches = 0;
	int checks = 0;
	always #2.5 clk = ~clk;
	bdm_core_model u_bdm_core_model (.clk_in(clk), .rdata_in(rdata), .file_addr_out(addr),
		.read_out(rd_s), .write_out(wr_s), .wdata_out(wd));
	bdm_register_file u_bdm_register_file (.CLOCK_IN(clk), .RST_IN(rst), .POWER_ON_RST_IN(por),
		.BROWN_OUT_RST_IN(bor), .FILE_ADDR_IN(addr), .READ_IN(rd_s), .WRITE_IN(wr_s), .WDATA_IN(wd),
		.PC_LOAD_IN(pc_ld), .PC_LOW_NEXT_IN(pc_nx), .STATUS_FLAGS_WE_IN(flg_we), .STATUS_FLAGS_IN(flg),
		.TIMEOUT_SET_IN(to_clr), .POWERDOWN_SET_IN(pd_clr), .PORT_A_PINS_IN(pins_a), .PORT_B_PINS_IN(pins_b),
		.RDATA_OUT(rdata), .PC_OUT(pc), .STATUS_OUT(status), .OPTIONS_OUT(opts), .INTERRUPT_CONTROL_OUT(intc),
		.PORT_A_DIRECTION_OUT(), .PORT_B_DIRECTION_OUT(dir_b), .CCP_PIN_DIRECTION_OUT(),
		.PERIPH_IRQ_ENABLES_OUT(), .CONVERTER_CONTROL_B_OUT());
	task print_verdict;
		$display("checks=%0d mismatches=%0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task chk8(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task w(input logic [6:0] a, input logic [7:0] d);
		u_bdm_core_model.wr(a, d);
	endtask
	task rc(input logic [6:0] a, input logic [7:0] exp);
		logic [7:0] d;
		u_bdm_core_model.rd(a, d);
		chk8(d, exp);
	endtask
	task pulse(input int k);
		@(negedge clk);
		rst = (k == 0);
		bor = (k == 1);
		por = (k == 2);
		@(negedge clk);
		rst = 1'b0;
		bor = 1'b0;
		por = 1'b0;
	endtask
	task t_reset_values;
		chk8(status, RST_STATUS_POR);
		chk8(dir_b, RST_ALL_ONES);
		chk8(opts, RST_ALL_ONES);
		chk8(intc, RST_ZERO);
		chk8(pc[7:0], 8'h00);
		rc(7'h0A, 8'h00);
		pins_b = 8'h3C;
		pins_a = 8'hEA;
		repeat (2) @(negedge clk);
		rc(7'h06, 8'h3C);
		rc(7'h05, 8'h2A);
		$display("test reset_values done");
	endtask
	task t_bank_map;
		w(7'h20, 8'h5A);
		w(7'h7F, 8'hC3);
		rc(7'h20, 8'h5A);
		rc(7'h7F, 8'hC3);
		rc(7'h08, 8'h00);
		w(7'h0C, 8'hFF);
		rc(7'h0C, MASK_PIR);
		w(7'h03, 8'hE0);
		chk8(status, 8'h38);
		w(7'h20, 8'h77);
		rc(7'h20, 8'h77);
		rc(7'h40, 8'h00);
		w(7'h0C, 8'hFF);
		rc(7'h0C, MASK_PIE);
		w(7'h0A, 8'hFF);
		w(7'h03, 8'h00);
		rc(7'h0A, MASK_PC_HIGH);
		rc(7'h20, 8'h5A);
		$display("test bank_map done");
	endtask
	task t_indirect;
		w(7'h04, 8'h21);
		w(7'h00, 8'h3C);
		rc(7'h21, 8'h3C);
		rc(7'h00, 8'h3C);
		w(7'h04, 8'hA0);
		rc(7'h00, 8'h77);
		w(7'h04, 8'h00);
		rc(7'h00, 8'h00);
		$display("test indirect done");
	endtask
	task t_pc_load;
		w(7'h0A, 8'h15);
		@(negedge clk);
		pc_ld = 1'b1;
		pc_nx = 8'h34;
		@(negedge clk);
		pc_ld = 1'b0;
		chk8(pc[7:0], 8'h34);
		chk8({3'h0, pc[12:8]}, 8'h15);
		w(7'h0A, 8'h0B);
		w(7'h02, 8'h99);
		chk8({3'h0, pc[12:8]}, 8'h0B);
		rc(7'h02, 8'h99);
		$display("test pc_load done");
	endtask
	task t_resets;
		w(7'h04, 8'h5A);
		w(7'h03, 8'h20);
		w(7'h06, 8'h00);
		w(7'h01, 8'h00);
		w(7'h0B, 8'h81);
		chk8(dir_b, 8'h00);
		chk8(opts, 8'h00);
		chk8(intc, 8'h81);
		pulse(0);
		chk8(dir_b, RST_ALL_ONES);
		chk8(status, RST_STATUS_POR);
		chk8(opts, RST_ALL_ONES);
		chk8(intc, 8'h01);
		rc(7'h04, 8'h5A);
		rc(7'h0C, MASK_PIR);
		pulse(1);
		chk8(intc, RST_ZERO);
		rc(7'h04, 8'h00);
		rc(7'h0C, 8'h00);
		w(7'h03, 8'h20);
		rc(7'h0E, RST_POWER_RESET_FLAGS_BOR);
		pulse(2);
		w(7'h03, 8'h20);
		rc(7'h0E, RST_POWER_RESET_FLAGS_POR);
		rc(7'h12, RST_ALL_ONES);
		$display("test resets done");
	endtask
	task t_status_flags;
		@(negedge clk);
		to_clr = 1'b1;
		flg_we = 1'b1;
		flg = 3'h5;
		@(negedge clk);
		to_clr = 1'b0;
		flg_we = 1'b0;
		chk8(status, 8'h2D);
		pulse(0);
		chk8(status, 8'h0D);
		@(negedge clk);
		pd_clr = 1'b1;
		@(negedge clk);
		pd_clr = 1'b0;
		chk8(status, 8'h05);
		pulse(1);
		chk8(status, RST_STATUS_POR);
		$display("test status_flags done");
	endtask
	initial
	begin
		repeat (20000) @(posedge clk);
		mismatches++;
		print_verdict();
	end
	initial
	begin
		repeat (10) @(negedge clk);
		rst = 1'b0;
		por = 1'b0;
		t_reset_values();
		t_bank_map();
		t_indirect();
		t_pc_load();
		t_resets();
		t_status_flags();
		print_verdict();
	end
endmodule
`default_nettype wire
